// ==== src/ips_pkg.sv ====
// constants, types and pin bundles of the input power-up sequencer
package ips_pkg;

	// ****************************************************************
	// clock and timing
	// ****************************************************************
	localparam int unsigned CLK_HZ      = 200_000_000; // mclk rate
	localparam int unsigned CYC_PER_MS  = CLK_HZ / 1000;
	localparam int unsigned T_BIAS_MS   = 220;  // bias regulator delay
	localparam int unsigned T_QUAL_MS   = 30;   // test load duration
	localparam int unsigned T_RETRY_S   = 2;    // poor source retry
	localparam int unsigned T_DCDSRC_MS = 13;   // dcd source on time
	localparam int unsigned T_DCDTMO_MS = 500;  // dcd timeout, 0.5 s
	localparam int unsigned T_PRI_MS    = 40;   // primary detection
	localparam int unsigned T_SEC_MS    = 40;   // secondary detection
	localparam int unsigned T_BOOST_MS  = 30;   // boost start delay
	localparam int unsigned C_BIAS      = T_BIAS_MS * CYC_PER_MS;
	localparam int unsigned C_QUAL      = T_QUAL_MS * CYC_PER_MS;
	localparam int unsigned C_RETRY     = T_RETRY_S * CLK_HZ;
	localparam int unsigned C_DCDSRC    = T_DCDSRC_MS * CYC_PER_MS;
	localparam int unsigned C_DCDTMO    = T_DCDTMO_MS * CYC_PER_MS;
	localparam int unsigned C_PRI       = T_PRI_MS * CYC_PER_MS;
	localparam int unsigned C_SEC       = T_SEC_MS * CYC_PER_MS;
	localparam int unsigned C_BOOST     = T_BOOST_MS * CYC_PER_MS;
	localparam int unsigned SW_HZ       = 1_500_000; // switching rate
	localparam int unsigned SW_DIV      = CLK_HZ / SW_HZ; // 133

	// ****************************************************************
	// limits, milliamps and millivolts
	// ****************************************************************
	localparam logic [11:0] ICL_CDP   = 12'h05DC; // 1500 mA
	localparam logic [11:0] ICL_DCP   = 12'h0960; // 2400 mA
	localparam logic [11:0] ICL_DIV1  = 12'h0834; // 2100 mA
	localparam logic [11:0] ICL_DIV2  = 12'h07D0; // 2000 mA
	localparam logic [11:0] ICL_DIV3  = 12'h03E8; // 1000 mA
	localparam logic [11:0] ICL_DIV4  = 12'h0960; // 2400 mA
	localparam logic [11:0] ICL_SOFT  = 12'h00C8; // 200 mA clamp
	localparam logic [12:0] VLIM_FIX  = 13'h10CC; // 4300 mV
	localparam logic [12:0] VLIM_OFS  = 13'h00C8; // 200 mV above bat
	localparam logic [12:0] BST_VOUT  = 13'h1388; // 5000 mV
	localparam logic [11:0] BST_IOUT  = 12'h04B0; // 1200 mA

	// ****************************************************************
	// enumerations
	// ****************************************************************
	typedef enum logic [3:0] {
		PT_NONE = 4'h0, PT_SDP  = 4'h1, PT_CDP  = 4'h2, PT_DCP = 4'h3,
		PT_DIV1 = 4'h4, PT_DIV2 = 4'h5, PT_DIV3 = 4'h6, PT_DIV4 = 4'h7,
		PT_UNKNOWN = 4'h8
	} ips_port_t;

	typedef enum logic [12:0] {
		S_IDLE   = 13'h0001, S_BIAS   = 13'h0002, S_QUAL   = 13'h0004,
		S_RETRY  = 13'h0008, S_DCDON  = 13'h0010, S_DCDWT  = 13'h0020,
		S_PRI    = 13'h0040, S_SEC    = 13'h0080, S_NONSTD = 13'h0100,
		S_VLIM   = 13'h0200, S_RUN    = 13'h0400, S_BSTWT  = 13'h0800,
		S_BSTRUN = 13'h1000
	} ips_state_t;

	// ****************************************************************
	// pin bundles
	// ****************************************************************
	typedef struct packed {
		logic        vbus_uvloz;         // vbus above uvlo release
		logic        vbus_above_sleepz;  // vbus > bat + sleepz
		logic        vbus_below_sleep;   // vbus < bat + sleep
		logic        hiz_mode;           // high impedance request
		logic        above_poor_source;  // vbus above poor threshold
		logic        dp_high;            // d+ above logic level
		logic        dm_above_ref;       // d- above data reference
		logic        dp_above_ref;       // d+ above data reference
		logic [3:0]  div_window;         // d+/d- in divider window n
		logic [11:0] limit_resistor_pin; // pin limit, mA
		logic [1:0]  vset_pin;           // voltage-set selection
		logic        charge_disable;     // charging disabled
		logic        sys_below_bat_short;
		logic        sys_above_bat_shortz;
		logic        vlim_tracking;      // tracking voltage limit mode
		logic [12:0] bat_mv;             // battery voltage, mV
		logic        boost_request_pin;
		logic        thermistor_in_window;
		logic        battery_discharge_overcurrent;
		logic        thermal_shutdown_fault;
		logic        input_overvoltage_fault;
		logic        bus_overvoltage_fault;
	} ips_in_t;

	typedef struct packed {
		logic        bias_regulator_en;
		logic        qual_test_load_en;  // about 30 mA test sink
		logic        dp_isrc_en;
		logic        dm_pulldown_en;
		logic        dp_vsrc_en;
		logic        dm_isink_en;
		logic        dm_vsrc_en;
		logic        dp_isink_en;
		logic [3:0]  port_type;
		logic        detect_done;
		logic [11:0] input_current_limit;
		logic [12:0] input_voltage_limit;
		logic [1:0]  vset_latched;
		logic        buck_switch_en;
		logic        switch_tick;        // 1.5 MHz pulse
		logic        battery_switch_on;
		logic        buck_pfm_allow;
		logic        boost_en;
		logic        boost_switch_en;
		logic        boost_pfm_allow;
		logic [12:0] boost_vout_mv;
		logic [11:0] boost_iout_ma;
	} ips_out_t;

endpackage

// ==== src/ips_seq.sv ====
// input source power-up sequencer with bc1.2 detection and boost gate
`timescale 1ns/100ps
// How it works
// - bias on after uvlo, sleep test, 220 ms
// - high impedance keeps bias off except in boost run, battery supplies
// - qualify source under 30 mA test load
// - failed qualification retried every 2 s
// - attach runs dcd, primary, secondary in order
// - dcd: d+ source, d- pulldown 13 ms
// - wait 0.5 s for d+ fall, else nonstandard
// - primary 40 ms: d- low means standard host
// - secondary 40 ms: d+ low means cdp
// - divider windows give 2.1/2/1/2.4 A
// - dcp 2.4 A, cdp 1.5 A
// - unknown adapter uses limit resistor pin
// - fixed 4.3 V or tracking battery plus 200 mV
// - switch after limit chosen; battery switch follows charging
// - 200 mA clamp while system below short
// - fixed 1.5 MHz switching enable
// - buck allows pulse-frequency operation by default
// - boost regulates 5 V, 1.2 A limit
// - boost only with request, sleep, thermistor, no fault
// - boost starts 30 ms after enable
// - boost allows pulse-frequency at light load
// - detection and vset latched only on attach
module ips_seq
	import ips_pkg::*;
#(
	parameter int unsigned P_BIAS   = C_BIAS,
	parameter int unsigned P_QUAL   = C_QUAL,
	parameter int unsigned P_RETRY  = C_RETRY,
	parameter int unsigned P_DCDSRC = C_DCDSRC,
	parameter int unsigned P_DCDTMO = C_DCDTMO,
	parameter int unsigned P_PRI    = C_PRI,
	parameter int unsigned P_SEC    = C_SEC,
	parameter int unsigned P_BOOST  = C_BOOST,
	parameter int unsigned P_SWDIV  = SW_DIV
) (
	input  wire logic    mclk,
	input  wire logic    rst_n,
	input  wire ips_in_t pins,
	output ips_out_t     ctl
);

	// ****************************************************************
	// elaboration checks
	// ****************************************************************
	// counters are 32 bits, divider 8 bits, every delay at least a cycle
	// the dcd timeout must outlast the contact source window
	if (P_BIAS < 1 || P_QUAL < 1 || P_RETRY < 1 || P_DCDSRC < 1 ||
	    P_DCDTMO <= P_DCDSRC || P_PRI < 1 || P_SEC < 1 ||
	    P_BOOST < 1) begin : g_chk_t
		$error("ips_seq: timing parameter out of range");
	end
	if (P_SWDIV < 2 || P_SWDIV > 256) begin : g_chk_d
		$error("ips_seq: switching divider out of range");
	end

	// ****************************************************************
	// state record
	// ****************************************************************
	typedef struct packed {
		ips_in_t     s1;      // synchroniser first stage
		ips_in_t     s2;      // synchronised inputs
		ips_state_t  fsm;     // sequence state
		logic [31:0] cnt;     // per-state delay counter
		logic [31:0] tmo;     // dcd overall timeout
		logic        seen_hi; // d+ seen high during dcd
		logic        clamp;   // soft-start current clamp
		logic [7:0]  div;     // switching divider
		logic [11:0] icl_det; // detected current limit
		ips_out_t    o;       // registered outputs
	} ips_st_t;

	ips_st_t r;      // current state record
	ips_st_t n;      // next state record
	ips_in_t i;      // synchronised view of pins
	logic    rs_m_r; // reset release first stage
	logic    rs_r;   // reset release, active high run
	logic    bias_ok;
	logic    bst_ok;
	logic    bst_hold;
	logic    buck_ph;

	assign i   = r.s2;
	assign ctl = r.o;

	// ****************************************************************
	// helpers
	// ****************************************************************
	// true on the last cycle of a delay of lim cycles
	function automatic logic hit(input logic [31:0] c,
	                             input int unsigned lim);
		hit = (c >= 32'(lim - 1));
	endfunction

	// divider window to limit; no window means unknown adapter
	function automatic logic [15:0] div_dec(input logic [3:0] w,
	                                        input logic [11:0] pin);
		if (w[0]) begin
			div_dec = {PT_DIV1, ICL_DIV1};
		end else if (w[1]) begin
			div_dec = {PT_DIV2, ICL_DIV2};
		end else if (w[2]) begin
			div_dec = {PT_DIV3, ICL_DIV3};
		end else if (w[3]) begin
			div_dec = {PT_DIV4, ICL_DIV4};
		end else begin
			div_dec = {PT_UNKNOWN, pin};
		end
	endfunction

	// higher of fixed level and battery plus offset in tracking mode
	function automatic logic [12:0] vlim(input logic trk,
	                                     input logic [12:0] bat);
		logic [12:0] t;
		t = 13'(bat + VLIM_OFS);
		if (trk && t > VLIM_FIX) begin
			vlim = t;
		end else begin
			vlim = VLIM_FIX;
		end
	endfunction

	// ****************************************************************
	// qualifying conditions
	// ****************************************************************
	// buck side bias: uvlo, sleep comparator, not high impedance
	assign bias_ok  = i.vbus_uvloz && i.vbus_above_sleepz &&
	                  !i.hiz_mode;
	// boost hold: request, thermistor window and no fault at all
	assign bst_hold = i.boost_request_pin && i.thermistor_in_window &&
	                  !i.battery_discharge_overcurrent &&
	                  !i.thermal_shutdown_fault &&
	                  !i.input_overvoltage_fault &&
	                  !i.bus_overvoltage_fault;
	// sleep test only applies before the boost converter starts
	assign bst_ok   = bst_hold && i.vbus_below_sleep;
	// states in which the buck sequence owns the input
	assign buck_ph  = !(r.fsm == S_IDLE || r.fsm == S_BSTWT ||
	                    r.fsm == S_BSTRUN);

	// ****************************************************************
	// next-state logic
	// ****************************************************************
	// one pass works out the whole next record
	always_comb begin
		n      = r;
		n.s1   = pins;
		n.s2   = r.s1;
		n.cnt  = r.cnt + 32'h0000_0001;
		n.o.switch_tick = 1'b0;
		// fixed-rate enable, free of input or load conditions
		if (r.o.buck_switch_en || r.o.boost_switch_en) begin
			if (r.div == 8'(P_SWDIV - 1)) begin
				n.div = 8'h00;
				n.o.switch_tick = 1'b1;
			end else begin
				n.div = 8'(r.div + 8'h01);
			end
		end else begin
			n.div = 8'h00;
		end
		case (r.fsm)
			S_IDLE: begin
				n.cnt        = 32'h0000_0000;
				n.o.port_type   = PT_NONE;
				n.o.detect_done = 1'b0;
				if (bst_ok && !i.vbus_uvloz) begin
					n.fsm = S_BSTWT;
				end else if (bias_ok) begin
					n.fsm = S_BIAS;
				end
			end
			S_BIAS: begin
				// condition must hold for the whole delay
				if (hit(r.cnt, P_BIAS)) begin
					n.fsm = S_QUAL;
					n.cnt = 32'h0000_0000;
				end
			end
			S_QUAL: begin
				// any dip under load fails the attempt at once
				if (!i.above_poor_source) begin
					n.fsm = S_RETRY;
					n.cnt = 32'h0000_0000;
				end else if (hit(r.cnt, P_QUAL)) begin
					n.fsm     = S_DCDON;
					n.cnt     = 32'h0000_0000;
					n.tmo     = 32'h0000_0000;
					n.seen_hi = 1'b0;
				end
			end
			S_RETRY: begin
				if (hit(r.cnt, P_RETRY)) begin
					n.fsm = S_QUAL;
					n.cnt = 32'h0000_0000;
				end
			end
			S_DCDON, S_DCDWT: begin
				// a fall counts only after d+ was seen high
				n.tmo = r.tmo + 32'h0000_0001;
				if (i.dp_high) begin
					n.seen_hi = 1'b1;
				end
				if (r.seen_hi && !i.dp_high) begin
					n.fsm = S_PRI;
					n.cnt = 32'h0000_0000;
				end else if (hit(r.tmo, P_DCDTMO)) begin
					n.fsm = S_NONSTD;
				end else if (r.fsm == S_DCDON && hit(r.cnt, P_DCDSRC)) begin
					n.fsm = S_DCDWT;
				end
			end
			S_PRI: begin
				if (hit(r.cnt, P_PRI)) begin
					n.cnt = 32'h0000_0000;
					if (!i.dm_above_ref) begin
						// standard host: pin setting as limit
						n.o.port_type = PT_SDP;
						n.icl_det     = i.limit_resistor_pin;
						n.fsm         = S_VLIM;
					end else begin
						n.fsm = S_SEC;
					end
				end
			end
			S_SEC: begin
				if (hit(r.cnt, P_SEC)) begin
					if (!i.dp_above_ref) begin
						n.o.port_type = PT_CDP;
						n.icl_det     = ICL_CDP;
					end else begin
						n.o.port_type = PT_DCP;
						n.icl_det     = ICL_DCP;
					end
					n.fsm = S_VLIM;
				end
			end
			S_NONSTD: begin
				// one cycle to read the divider windows
				{n.o.port_type, n.icl_det} =
					div_dec(i.div_window, i.limit_resistor_pin);
				n.fsm = S_VLIM;
			end
			S_VLIM: begin
				// result and vset frozen until the next attach
				n.o.vset_latched = i.vset_pin;
				n.o.detect_done  = 1'b1;
				n.clamp          = 1'b1;
				n.fsm            = S_RUN;
			end
			S_RUN: begin
				// hysteresis between short and release levels
				if (i.sys_below_bat_short) begin
					n.clamp = 1'b1;
				end else if (i.sys_above_bat_shortz) begin
					n.clamp = 1'b0;
				end
			end
			S_BSTWT: begin
				// sleep margin only counts until the converter starts
				if (!bst_ok) begin
					n.fsm = S_IDLE;
				end else if (hit(r.cnt, P_BOOST)) begin
					n.fsm = S_BSTRUN;
				end
			end
			S_BSTRUN: begin
				if (!bst_hold) begin
					n.fsm = S_IDLE;
				end
			end
			default: begin
				n.fsm = S_IDLE;
			end
		endcase
		// detach, lost sleep margin or high impedance ends the buck
		if (buck_ph && !bias_ok) begin
			n.fsm = S_IDLE;
		end
		// outputs follow the state being entered
		n.o.bias_regulator_en = !(n.fsm == S_IDLE || n.fsm == S_BIAS ||
		                          n.fsm == S_BSTWT);
		n.o.qual_test_load_en = (n.fsm == S_QUAL);
		n.o.dp_isrc_en        = (n.fsm == S_DCDON);
		n.o.dm_pulldown_en    = (n.fsm == S_DCDON);
		n.o.dp_vsrc_en        = (n.fsm == S_PRI);
		n.o.dm_isink_en       = (n.fsm == S_PRI);
		n.o.dm_vsrc_en        = (n.fsm == S_SEC);
		n.o.dp_isink_en       = (n.fsm == S_SEC);
		n.o.buck_switch_en    = (n.fsm == S_RUN);
		n.o.buck_pfm_allow    = (n.fsm == S_RUN);
		// battery feeds the system whenever the buck is not running
		n.o.battery_switch_on = (n.fsm == S_RUN) ?
		                        !i.charge_disable : 1'b1;
		n.o.input_current_limit = (n.fsm != S_RUN) ? 12'h000 :
		                          n.clamp ? ICL_SOFT : n.icl_det;
		n.o.input_voltage_limit = vlim(i.vlim_tracking, i.bat_mv);
		n.o.boost_en          = (n.fsm == S_BSTWT ||
		                         n.fsm == S_BSTRUN);
		n.o.boost_switch_en   = (n.fsm == S_BSTRUN);
		n.o.boost_pfm_allow   = (n.fsm == S_BSTRUN);
		// no stray pulse on the cycle a converter stops
		n.o.switch_tick = n.o.switch_tick &&
		                  (n.o.buck_switch_en || n.o.boost_switch_en);
		n.o.boost_vout_mv     = BST_VOUT;
		n.o.boost_iout_ma     = BST_IOUT;
		if (n.fsm != r.fsm) begin
			n.cnt = 32'h0000_0000;
		end
	end

	// ****************************************************************
	// reset release
	// ****************************************************************
	// asynchronous assert, release after two edges
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rs_m_r <= 1'b0;
			rs_r   <= 1'b0;
		end else begin
			rs_m_r <= 1'b1;
			rs_r   <= rs_m_r;
		end
	end

	// ****************************************************************
	// state register
	// ****************************************************************
	// battery switch starts closed so the system stays fed
	always_ff @(posedge mclk or negedge rs_r) begin
		if (!rs_r) begin
			r                     <= '0;
			r.fsm                 <= S_IDLE;
			r.o.battery_switch_on <= 1'b1;
		end else begin
			r <= n;
		end
	end

endmodule

// ==== src/ips_dummy_none.sv ====
// no logic here; the whole sequencer sits in ips_seq.sv
`timescale 1ns/100ps

// ==== verif/ips_seq_assertions.sv ====
// port-level checks of the power-up sequencer
`timescale 1ns/100ps
module ips_seq_assertions
	import ips_pkg::*;
#(
	parameter int unsigned P_BIAS   = C_BIAS,
	parameter int unsigned P_QUAL   = C_QUAL,
	parameter int unsigned P_DCDSRC = C_DCDSRC,
	parameter int unsigned P_PRI    = C_PRI,
	parameter int unsigned P_BOOST  = C_BOOST
) (
	input wire logic     mclk,
	input wire logic     rst_n,
	input wire ips_in_t  pins,
	input wire ips_out_t ctl
);
	// ****************
	// run-length counters
	// ****************
	int unsigned ok_cnt;   // input good, raw pins
	int unsigned load_cnt; // test load on
	int unsigned dcd_cnt;  // d+ source on
	int unsigned pri_cnt;  // primary sources on
	int unsigned bw_cnt;   // waiting to boost

	// each count restarts when its condition drops
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ok_cnt   <= 0;
			load_cnt <= 0;
			dcd_cnt  <= 0;
			pri_cnt  <= 0;
			bw_cnt   <= 0;
		end else begin
			ok_cnt   <= (pins.vbus_uvloz && pins.vbus_above_sleepz &&
				!pins.hiz_mode) ? ok_cnt + 1 : 0;
			load_cnt <= ctl.qual_test_load_en ? load_cnt + 1 : 0;
			dcd_cnt  <= ctl.dp_isrc_en ? dcd_cnt + 1 : 0;
			pri_cnt  <= ctl.dp_vsrc_en ? pri_cnt + 1 : 0;
			bw_cnt   <= (ctl.boost_en && !ctl.boost_switch_en) ?
				bw_cnt + 1 : 0;
		end
	end

	// ****************
	// assertions
	// ****************
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);

	sequence s_pri_end;
		$fell(ctl.dp_vsrc_en) ##0 ctl.dm_vsrc_en;
	endsequence
	sequence s_sec_start;
		$rose(ctl.dm_vsrc_en);
	endsequence
	sequence s_wait_start;
		$rose(ctl.boost_en);
	endsequence

	a_bias_delay: assert property ($rose(ctl.bias_regulator_en) &&
		!ctl.boost_en |-> ok_cnt >= P_BIAS) else $error("bias early");
	a_qual_len: assert property (load_cnt <= P_QUAL)
		else $error("test load too long");
	a_dcd_pair: assert property (ctl.dp_isrc_en == ctl.dm_pulldown_en &&
		dcd_cnt <= P_DCDSRC) else $error("contact sources wrong");
	a_pri_len: assert property (s_pri_end |-> pri_cnt == P_PRI)
		else $error("primary length wrong");
	a_sec_order: assert property (s_sec_start |->
		$past(ctl.dp_vsrc_en) && ctl.dp_isink_en) else $error("bad order");
	a_sink_pair: assert property (ctl.dm_isink_en == ctl.dp_vsrc_en &&
		ctl.dp_isink_en == ctl.dm_vsrc_en) else $error("sink pairing wrong");
	a_limit_first: assert property (ctl.buck_switch_en |->
		ctl.detect_done && ctl.input_current_limit != 12'h000)
		else $error("switching before limit");
	a_clamp_soft: assert property (pins.sys_below_bat_short [*4] ##0
		ctl.buck_switch_en |-> ctl.input_current_limit == ICL_SOFT)
		else $error("soft clamp missing");
	a_tick_pulse: assert property (ctl.switch_tick |->
		(ctl.buck_switch_en || ctl.boost_switch_en) ##1 !ctl.switch_tick)
		else $error("bad switch tick");
	a_pfm_modes: assert property (ctl.buck_pfm_allow == ctl.buck_switch_en &&
		ctl.boost_pfm_allow == ctl.boost_switch_en) else $error("pfm");
	a_boost_out: assert property (ctl.boost_en |->
		ctl.boost_vout_mv == BST_VOUT && ctl.boost_iout_ma == BST_IOUT)
		else $error("boost targets wrong");
	a_boost_gate: assert property (s_wait_start |->
		$past(pins.boost_request_pin, 3) &&
		$past(pins.thermistor_in_window, 3)) else $error("boost ungated");
	a_boost_delay: assert property ($rose(ctl.boost_switch_en) |->
		bw_cnt == P_BOOST) else $error("boost delay wrong");
endmodule

bind ips_seq ips_seq_assertions #(.P_BIAS(P_BIAS), .P_QUAL(P_QUAL),
	.P_DCDSRC(P_DCDSRC), .P_PRI(P_PRI), .P_BOOST(P_BOOST)) u_chk (
	.mclk(mclk), .rst_n(rst_n), .pins(pins), .ctl(ctl));

// ==== verif/ips_port_model.sv ====
// usb port or adapter model on the data lines
`timescale 1ns/100ps
module ips_port_model
	import ips_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic [3:0] kind,
	input  wire ips_out_t   ctl,
	output logic            dp_high,
	output logic            dm_above_ref,
	output logic            dp_above_ref,
	output logic [3:0]      div_window
);
	logic [3:0] touch_cnt = 4'h0; // d+ source cycles so far
	logic       tog       = 1'b0; // unsensed line, never steady
	logic       std;              // bc1.2 port, not an adapter

	assign std = kind inside {PT_SDP, PT_CDP, PT_DCP};

	// contact is made a few cycles after the d+ source starts
	always_ff @(posedge mclk) begin
		tog <= ~tog;
		if (!ctl.dp_isrc_en) begin
			touch_cnt <= 4'h0;
		end else if (touch_cnt != 4'hf) begin
			touch_cnt <= touch_cnt + 4'h1;
		end
	end

	// host pull-down wins after contact; adapters hold d+ up
	assign dp_high = std ? (ctl.dp_isrc_en && touch_cnt < 4'h3) :
		1'b1;
	// charging ports echo d+ onto d-, a host does not
	assign dm_above_ref = ctl.dp_vsrc_en ? (std && kind != PT_SDP) :
		tog;
	// only a dedicated port shorts the two lines
	assign dp_above_ref = ctl.dm_vsrc_en ? (kind == PT_DCP) : tog;
	// each divider sits in its own window
	assign div_window = (kind >= PT_DIV1 && kind <= PT_DIV4) ?
		4'(4'h1 << (kind - 4'h4)) : 4'h0;
endmodule

// ==== verif/tb.sv ====
// bench for the power-up sequencer: attach, detection, boost
`timescale 1ns/100ps
module tb
	import ips_pkg::*;
;
	// ****************
	// shortened timing
	// ****************
	localparam int unsigned TB_BIAS  = 40;
	localparam int unsigned TB_RETRY = 50;
	localparam int unsigned TB_BOOST = 10;
	localparam int unsigned TB_SWDIV = 4;
	localparam logic [11:0] PIN_LIM  = 12'h0640; // 1600 mA

	logic       mclk     = 1'b0;
	logic       rst_n    = 1'b0;
	logic [3:0] kind     = 4'h0; // what the model presents
	ips_in_t    pv;              // bench side of the pins
	ips_in_t    pins;            // with model comparators merged
	ips_out_t   ctl;
	logic       m_dph;
	logic       m_dma;
	logic       m_dpa;
	logic [3:0] m_div;
	int         failures = 0;
	int         checked  = 0;

	always #2.5 mclk = ~mclk;

	// data-line comparators come from the model
	always_comb begin
		pins              = pv;
		pins.dp_high      = m_dph;
		pins.dm_above_ref = m_dma;
		pins.dp_above_ref = m_dpa;
		pins.div_window   = m_div;
	end

	ips_port_model u_port (.mclk(mclk), .kind(kind), .ctl(ctl),
		.dp_high(m_dph), .dm_above_ref(m_dma), .dp_above_ref(m_dpa),
		.div_window(m_div));

	ips_seq #(.P_BIAS(TB_BIAS), .P_QUAL(10), .P_RETRY(TB_RETRY),
		.P_DCDSRC(5), .P_DCDTMO(30), .P_PRI(8), .P_SEC(8),
		.P_BOOST(TB_BOOST), .P_SWDIV(TB_SWDIV)) dut (.mclk(mclk),
		.rst_n(rst_n), .pins(pins), .ctl(ctl));

	// ****************
	// helpers
	// ****************
	task automatic chk(input string nm, input logic [15:0] seen, exp);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// drive and sample just after the edge
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	task automatic plug(input ips_port_t k);
		int n;
		n = 0;
		kind = k;
		pv.vbus_uvloz = 1'b1;
		pv.vbus_above_sleepz = 1'b1;
		while (ctl.detect_done !== 1'b1 && n < 400) begin
			tick(1);
			n++;
		end
		chk("detect_done", ctl.detect_done, 1'b1);
	endtask

	task automatic unplug();
		pv.vbus_uvloz = 1'b0;
		pv.vbus_above_sleepz = 1'b0;
		tick(8);
		chk("off_bias", ctl.bias_regulator_en, 1'b0);
		chk("off_type", ctl.port_type, PT_NONE);
		pv.sys_below_bat_short = 1'b1;
		pv.sys_above_bat_shortz = 1'b0;
	endtask

	// ****************
	// scenarios
	// ****************
	task automatic t_hiz();
		pv.hiz_mode = 1'b1;
		pv.vbus_uvloz = 1'b1;
		pv.vbus_above_sleepz = 1'b1;
		tick(TB_BIAS + 20);
		chk("hiz_bias", ctl.bias_regulator_en, 1'b0);
		chk("hiz_bat", ctl.battery_switch_on, 1'b1);
		pv.hiz_mode = 1'b0;
		tick(TB_BIAS);
		chk("bias_wait", ctl.bias_regulator_en, 1'b0);
		plug(PT_SDP);
		unplug();
	endtask

	// every port kind, then clamp release to the chosen limit
	task automatic t_detect();
		ips_port_t   k [8] = '{PT_SDP, PT_CDP, PT_DCP, PT_DIV1,
			PT_DIV2, PT_DIV3, PT_DIV4, PT_UNKNOWN};
		logic [11:0] lim [8] = '{PIN_LIM, ICL_CDP, ICL_DCP, ICL_DIV1,
			ICL_DIV2, ICL_DIV3, ICL_DIV4, PIN_LIM};
		for (int i = 0; i < 8; i++) begin
			pv.charge_disable = i[0];
			plug(k[i]);
			chk("port_type", ctl.port_type, k[i]);
			chk("clamp", ctl.input_current_limit, ICL_SOFT);
			chk("vlim_fix", ctl.input_voltage_limit, VLIM_FIX);
			chk("bat_sw", ctl.battery_switch_on, !i[0]);
			chk("buck_on", ctl.buck_switch_en, 1'b1);
			pv.sys_below_bat_short = 1'b0;
			pv.sys_above_bat_shortz = 1'b1;
			tick(6);
			chk("limit", ctl.input_current_limit, lim[i]);
			unplug();
		end
	endtask

	task automatic t_retry();
		int n;
		n = 0;
		pv.above_poor_source = 1'b0;
		pv.vbus_uvloz = 1'b1;
		pv.vbus_above_sleepz = 1'b1;
		while (ctl.qual_test_load_en !== 1'b1 && n < 200) begin
			tick(1);
			n++;
		end
		while (ctl.qual_test_load_en === 1'b1 && n < 200) begin
			tick(1);
			n++;
		end
		n = 0;
		while (ctl.qual_test_load_en !== 1'b1 && n < 200) begin
			tick(1);
			n++;
		end
		chk("retry_gap", n, TB_RETRY);
		chk("retry_done", ctl.detect_done, 1'b0);
		pv.above_poor_source = 1'b1;
		plug(PT_DCP);
		unplug();
	endtask

	// tracking limit, then late pin changes are ignored
	task automatic t_vlim();
		pv.vlim_tracking = 1'b1;
		pv.bat_mv = 13'h1068;
		pv.vset_pin = 2'h2;
		plug(PT_CDP);
		chk("vlim_trk", ctl.input_voltage_limit, pv.bat_mv + VLIM_OFS);
		chk("vset", ctl.vset_latched, 2'h2);
		pv.vset_pin = 2'h1;
		kind = PT_DCP;
		tick(10);
		chk("vset_hold", ctl.vset_latched, 2'h2);
		chk("type_hold", ctl.port_type, PT_CDP);
		pv.vlim_tracking = 1'b0;
		unplug();
	endtask

	task automatic t_boost();
		int n;
		n = 0;
		pv.vbus_below_sleep = 1'b1;
		pv.boost_request_pin = 1'b1;
		tick(20);
		chk("bst_cold", ctl.boost_en, 1'b0);
		pv.thermistor_in_window = 1'b1;
		while (ctl.boost_en !== 1'b1 && n < 20) begin
			tick(1);
			n++;
		end
		n = 0;
		while (ctl.boost_switch_en !== 1'b1 && n < 50) begin
			tick(1);
			n++;
		end
		chk("bst_delay", n, TB_BOOST);
		chk("bst_v", ctl.boost_vout_mv, BST_VOUT);
		chk("bst_i", ctl.boost_iout_ma, BST_IOUT);
		chk("bst_pfm", ctl.boost_pfm_allow, 1'b1);
		n = 0;
		repeat (4 * TB_SWDIV) begin
			tick(1);
			n += ctl.switch_tick;
		end
		chk("ticks", n, 4);
		pv.thermal_shutdown_fault = 1'b1;
		tick(2);
		chk("bst_sync", ctl.boost_en, 1'b1);
		tick(3);
		chk("bst_fault", ctl.boost_en, 1'b0);
	endtask

	task automatic give_verdict();
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// main sequence
	initial begin
		pv = '0;
		pv.above_poor_source = 1'b1;
		pv.sys_below_bat_short = 1'b1;
		pv.limit_resistor_pin = PIN_LIM;
		repeat (10) @(posedge mclk);
		#1;
		rst_n = 1'b1;
		tick(4);
		t_hiz();
		t_detect();
		t_retry();
		t_vlim();
		t_boost();
		give_verdict();
	end

	// hang guard, well beyond the expected run
	initial begin
		repeat (30000) @(posedge mclk);
		failures++;
		give_verdict();
	end
endmodule
